// ===== design/lmva_map.svh
// Constants for the loop mode and vector address slice.
// Assumes inclusion by both design files; definitions only.
`ifndef LMVA_MAP_SVH
`define LMVA_MAP_SVH
`define LMVA_LOOP_DISP      16'hfffc
`define LMVA_VEC_SHIFT      2
`define LMVA_VBR_RESET      32'h0000_0000
`define LMVA_RESET_SSP_ADDR 32'h0000_0000
`define LMVA_RESET_PC_ADDR  32'h0000_0004
`define LMVA_FC_SUP_DATA    3'h5
`define LMVA_FC_SUP_PROG    3'h6
`define LMVA_TABLE_BYTES    1024
`define LMVA_VEC_COUNT      256
`endif

// ===== design/lmva_pkg.sv
// Types shared by the loop mode and vector address slice.
// Assumes lmva_map.svh holds the numeric constants.
package lmva_pkg;
    typedef enum logic [1:0] {
        LMVA_KIND_RESET,
        LMVA_KIND_EXT,
        LMVA_KIND_INT
    } lmva_kind_t;

    typedef enum {
        LMVA_EX_IDLE,
        LMVA_EX_SR,
        LMVA_EX_VEC,
        LMVA_EX_FETCH0,
        LMVA_EX_FETCH1,
        LMVA_EX_SAVE,
        LMVA_EX_LOAD
    } lmva_exst_t;
endpackage

// ===== design/lmva_vec_if.sv
// Carries one vector fetch request from the sequencer to the address former.
// Assumes a single core clock on both ends.
`timescale 1ns/1ps
interface lmva_vec_if;
    logic [7:0]  vec_num;
    logic        second_word;
    logic        is_reset;
    logic [31:0] base;
    logic [31:0] addr;
    logic [2:0]  fc;
    modport seq (output vec_num, output second_word, output is_reset, output base,
                 input addr, input fc);
    modport former (input vec_num, input second_word, input is_reset, input base,
                    output addr, output fc);
endinterface

// ===== design/lmva_vec_former.sv
// Forms vector fetch address and function code from number and table base.
// Assumes requests are held stable by the sequencer.
`timescale 1ns/1ps
`include "lmva_map.svh"
module lmva_vec_former (
    lmva_vec_if.former vif
);
    import lmva_pkg::*;

    function automatic logic [31:0] vec_offset(input logic [7:0] num);
        vec_offset = 32'(num) << `LMVA_VEC_SHIFT;
    endfunction

    always_comb begin
        if (vif.is_reset) begin
            // Reset vector sits at a fixed place in program space
            vif.addr = vif.second_word ? `LMVA_RESET_PC_ADDR : `LMVA_RESET_SSP_ADDR;
            vif.fc   = `LMVA_FC_SUP_PROG;
        end else begin
            vif.addr = vif.base + vec_offset(vif.vec_num);
            vif.fc   = `LMVA_FC_SUP_DATA;
        end
    end
endmodule

// ===== design/lmva_core.sv
// How it works
// - Decrement-and-branch with displacement -4 enters loop mode.
// - Only single-word, non-flow-changing bodies qualify for loop mode.
// - In loop mode, only data cycles run; instruction fetches suppressed.
// - After each body pass, check termination and decrement the count.
// - Any taken exception or interrupt ends loop mode, fetching resumes.
// - Table base addresses a 1024-byte table of 256 vectors.
// - One long word per vector; reset takes stack pointer then PC.
// - Vector address is table base plus vector number times four.
// - Vector number comes from the device on acknowledge, else internal.
// - Vector fetches are supervisor data, reset fetches supervisor program.
// - Only reset vector place is fixed; others follow the table base.
// - Page fault saves a little state, restores, refetches, restarts.
// - Low-power halt stops the core and bus modules until exit event.
// - Exception steps: status copy, vector, save context (skipped on reset), load context.
//
// Top of the slice; the instruction decoder and bus engine sit outside.
// Assumes one core clock and that fetch and data strobes come from the decoder.
`timescale 1ns/1ps
`include "lmva_map.svh"
module lmva_core #(
    parameter int VBR_WIDTH = 32
) (
    input  wire logic        core_clk_in,
    input  wire logic        rst_n_in,
    input  wire logic        cond_decrement_branch_exec_in,
    input  wire logic [15:0] cond_decrement_branch_disp_in,
    input  wire logic        cond_decrement_branch_cond_true_in,
    input  wire logic [15:0] cond_decrement_branch_count_in,
    input  wire logic        body_single_word_in,
    input  wire logic        body_flow_change_in,
    input  wire logic        body_data_done_in,
    input  wire logic        fetch_req_in,
    input  wire logic        data_req_in,
    input  wire logic        exc_req_in,
    input  wire lmva_pkg::lmva_kind_t exc_kind_in,
    input  wire logic [7:0]  exc_int_vec_in,
    input  wire logic [7:0]  ack_vec_in,
    input  wire logic        ack_valid_in,
    input  wire logic        page_fault_in,
    input  wire logic        fault_fixed_in,
    input  wire logic        vbr_wr_in,
    input  wire logic [31:0] vbr_data_in,
    input  wire logic        bus_done_in,
    input  wire logic        low_power_halt_instr_exec_in,
    input  wire logic        wake_event_in,
    output logic             loop_active_out,
    output logic             fetch_grant_out,
    output logic             data_grant_out,
    output logic [15:0]      loop_count_out,
    output logic             loop_exit_out,
    output logic [31:0]      vbr_out,
    output logic             iack_out,
    output logic             vec_fetch_out,
    output logic [31:0]      vec_addr_out,
    output logic [2:0]       vec_fc_out,
    output logic [1:0]       exc_step_out,
    output logic             sr_copy_out,
    output logic             ctx_save_out,
    output logic             ctx_load_out,
    output logic             restart_out,
    output logic [31:0]      restart_pc_out,
    output logic             core_halted_out,
    output logic             bus_shutdown_out,
    input  wire logic [31:0] cur_pc_in
);
    import lmva_pkg::*;

    // Table base logic is written for a full 32-bit base only
    if (VBR_WIDTH != 32) begin : g_width_check
        $error("VBR_WIDTH must be 32");
    end

    typedef struct packed {
        logic        loop;
        logic [15:0] count;
        logic        exit_p;
        logic [31:0] vector_table_base;
        lmva_exst_t  st;
        logic [7:0]  vec;
        logic        reset_kind;
        logic        word1;
        logic        faulted;
        logic [31:0] saved_pc;
        logic        restart;
        logic        halted;
    } lmva_state_t;

    lmva_state_t s_reg;
    lmva_state_t s_next;
    lmva_vec_if  vif ();

    lmva_vec_former u_former (
        .vif (vif)
    );

    assign vif.vec_num     = s_reg.vec;
    assign vif.second_word = s_reg.word1;
    assign vif.is_reset    = s_reg.reset_kind;
    assign vif.base        = s_reg.vector_table_base;

    ////////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        s_next        = s_reg;
        s_next.exit_p = 1'b0;
        s_next.restart = 1'b0;
        // Loop entry on short backward branch
        if (!s_reg.loop && s_reg.st == LMVA_EX_IDLE && cond_decrement_branch_exec_in && !cond_decrement_branch_cond_true_in
            && cond_decrement_branch_disp_in == `LMVA_LOOP_DISP && body_single_word_in && !body_flow_change_in
            && cond_decrement_branch_count_in != 16'h0000) begin
            s_next.loop  = 1'b1;
            s_next.count = cond_decrement_branch_count_in - 16'h0001;
        end else if (s_reg.loop && body_data_done_in) begin
            // Termination and count test after each pass
            if (cond_decrement_branch_cond_true_in || s_reg.count == 16'h0000) begin
                s_next.loop   = 1'b0;
                s_next.exit_p = 1'b1;
            end else begin
                s_next.count = s_reg.count - 16'h0001;
            end
        end
        if (vbr_wr_in) begin
            s_next.vector_table_base = vbr_data_in;
        end
        // Low-power halt until an exit event
        if (low_power_halt_instr_exec_in && s_reg.st == LMVA_EX_IDLE) begin
            s_next.halted = 1'b1;
        end
        if (s_reg.halted && wake_event_in) begin
            s_next.halted = 1'b0;
        end
        // Page fault: keep PC, restart after fix
        if (page_fault_in && !s_reg.faulted) begin
            s_next.faulted  = 1'b1;
            s_next.saved_pc = cur_pc_in;
            s_next.loop     = 1'b0;
        end else if (s_reg.faulted && fault_fixed_in) begin
            s_next.faulted = 1'b0;
            s_next.restart = 1'b1;
        end
        // Exception sequence
        case (s_reg.st)
            LMVA_EX_IDLE: begin
                if (exc_req_in) begin
                    s_next.st         = LMVA_EX_SR;
                    s_next.loop       = 1'b0;
                    s_next.exit_p     = s_reg.loop;
                    s_next.halted     = 1'b0;
                    s_next.reset_kind = (exc_kind_in == LMVA_KIND_RESET);
                    s_next.word1      = 1'b0;
                    s_next.vec        = exc_int_vec_in;
                end
            end
            LMVA_EX_SR: begin
                s_next.st = LMVA_EX_VEC;
            end
            LMVA_EX_VEC: begin
                // External number on acknowledge, else internal
                if (exc_kind_in != LMVA_KIND_EXT) begin
                    s_next.st = LMVA_EX_FETCH0;
                end else if (ack_valid_in) begin
                    s_next.vec = ack_vec_in;
                    s_next.st  = LMVA_EX_FETCH0;
                end
            end
            LMVA_EX_FETCH0: begin
                if (bus_done_in) begin
                    // Reset fetches a second long word
                    s_next.st    = s_reg.reset_kind ? LMVA_EX_FETCH1 : LMVA_EX_SAVE;
                    s_next.word1 = s_reg.reset_kind;
                end
            end
            LMVA_EX_FETCH1: begin
                if (bus_done_in) begin
                    s_next.st = LMVA_EX_LOAD;
                end
            end
            LMVA_EX_SAVE: begin
                if (bus_done_in) begin
                    s_next.st = LMVA_EX_LOAD;
                end
            end
            LMVA_EX_LOAD: begin
                s_next.st         = LMVA_EX_IDLE;
                s_next.reset_kind = 1'b0;
                s_next.word1      = 1'b0;
            end
            default: begin
                s_next.st = LMVA_EX_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            s_reg       <= '0;
            s_reg.vector_table_base   <= `LMVA_VBR_RESET;
            s_reg.st    <= LMVA_EX_IDLE;
        end else begin
            s_reg <= s_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    logic busy_w;
    assign busy_w = (s_reg.st != LMVA_EX_IDLE) || s_reg.halted || s_reg.faulted;

    assign loop_active_out  = s_reg.loop;
    assign fetch_grant_out  = fetch_req_in && !s_reg.loop && !busy_w;
    assign data_grant_out   = data_req_in && !busy_w;
    assign loop_count_out   = s_reg.count;
    assign loop_exit_out    = s_reg.exit_p;
    assign vbr_out          = s_reg.vector_table_base;
    assign iack_out         = (s_reg.st == LMVA_EX_VEC) && (exc_kind_in == LMVA_KIND_EXT);
    assign vec_fetch_out    = (s_reg.st == LMVA_EX_FETCH0) || (s_reg.st == LMVA_EX_FETCH1);
    assign vec_addr_out     = vif.addr;
    assign vec_fc_out       = vif.fc;
    assign sr_copy_out      = (s_reg.st == LMVA_EX_SR);
    assign ctx_save_out     = (s_reg.st == LMVA_EX_SAVE);
    assign ctx_load_out     = (s_reg.st == LMVA_EX_LOAD);
    assign exc_step_out     = (s_reg.st == LMVA_EX_SR) ? 2'h0 :
                              (s_reg.st == LMVA_EX_VEC) ? 2'h1 :
                              (s_reg.st == LMVA_EX_SAVE) ? 2'h2 : 2'h3;
    assign restart_out      = s_reg.restart;
    assign restart_pc_out   = s_reg.saved_pc;
    assign core_halted_out  = s_reg.halted;
    assign bus_shutdown_out = s_reg.halted;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    chk_loop_no_fetch: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        loop_active_out |-> !fetch_grant_out) else $error("fetch granted in loop mode");
    chk_loop_entry: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        (!s_reg.loop && s_reg.st == LMVA_EX_IDLE && cond_decrement_branch_exec_in && !cond_decrement_branch_cond_true_in
         && cond_decrement_branch_disp_in == `LMVA_LOOP_DISP
         && body_single_word_in && !body_flow_change_in && cond_decrement_branch_count_in != 16'h0 && !exc_req_in
         && !page_fault_in) |=> loop_active_out) else $error("loop mode not entered");
    chk_loop_body: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        (!s_reg.loop && (body_flow_change_in || !body_single_word_in)) |=> !loop_active_out)
        else $error("bad body looped");
    chk_loop_count: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        (s_reg.loop && body_data_done_in && !cond_decrement_branch_cond_true_in && s_reg.count != 16'h0
         && !exc_req_in && !page_fault_in) |=> loop_count_out == $past(loop_count_out) - 16'h1)
        else $error("loop count not decremented");
    chk_exc_exit: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        (s_reg.st == LMVA_EX_IDLE && exc_req_in) |=> !loop_active_out ##1 !loop_active_out)
        else $error("loop survived exception");
    chk_vec_addr: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        (vec_fetch_out && !s_reg.reset_kind) |-> vec_addr_out == vbr_out + {22'h0, s_reg.vec, 2'h0}
        && vec_fc_out == `LMVA_FC_SUP_DATA) else $error("vector address wrong");
    chk_reset_fetch: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        (s_reg.st == LMVA_EX_FETCH0 && s_reg.reset_kind && bus_done_in) |=>
        (s_reg.st == LMVA_EX_FETCH1 && vec_addr_out == `LMVA_RESET_PC_ADDR && vec_fc_out == `LMVA_FC_SUP_PROG))
        else $error("reset second word wrong");
    chk_exc_order: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        sr_copy_out |=> exc_step_out == 2'h1) else $error("exception step order");
    chk_halt_bus: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        (low_power_halt_instr_exec_in && s_reg.st == LMVA_EX_IDLE && !exc_req_in && !wake_event_in)
        |=> bus_shutdown_out && !data_grant_out) else $error("halt not taken");
    chk_fault_restart: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
        (s_reg.faulted && fault_fixed_in) |=> restart_out && restart_pc_out == $past(s_reg.saved_pc))
        else $error("restart missing");
endmodule

// ===== dv/lmva_mem_model.sv
// Memory and interrupting device on the far side of the core slice.
// Assumes requests are held until answered; answers change at the falling edge.
`timescale 1ns/1ps
module lmva_mem_model (
    input  wire logic       clk_in,
    input  wire logic       iack_in,
    input  wire logic       bus_req_in,
    input  wire logic [1:0] dly_in,
    input  wire logic [7:0] vec_in,
    output logic            bus_done_out,
    output logic            ack_valid_out,
    output logic [7:0]      ack_vec_out
);
    logic [1:0] cnt;
    initial begin
        {cnt, bus_done_out, ack_valid_out} = '0;
        ack_vec_out = 8'h00;
    end
    ////////////////////////////////////////////////////////////////////////
    // Answer after dly_in idle cycles; vector lines inverted when not valid
    always @(negedge clk_in) begin
        bus_done_out <= 1'b0;
        ack_valid_out <= 1'b0;
        ack_vec_out <= ~vec_in;
        cnt <= 2'h0;
        if ((iack_in || bus_req_in) && !bus_done_out && !ack_valid_out) begin
            cnt <= cnt + 2'h1;
            if (cnt >= dly_in) begin
                cnt <= 2'h0;
                bus_done_out <= bus_req_in;
                ack_valid_out <= iack_in;
                if (iack_in) ack_vec_out <= vec_in;
            end
        end
    end
endmodule

// ===== dv/loop_mode_vector_address_tb_top.sv
// Self-checking bench for the loop mode and vector address slice.
// Assumes lmva_mem_model answers vector fetches, stack saves and acknowledges.
`timescale 1ns/1ps
module loop_mode_vector_address_tb_top;
    import lmva_pkg::*;
    logic        clk, rst_n, dbx, cond, bdone, freq, dreq, exq, pf, ffix, vwr, lps, wake, sw, flow;
    logic        ack_valid, bus_done, lact, fg, dg, lexit, iack, vf, srcp, csave, cload, rs, hlt, shut;
    logic [15:0] disp, lcnt, dcnt;
    logic [7:0]  dvec, ack_vec;
    logic [31:0] vdata, pc, vector_table_base, vaddr, rpc, vbr_exp;
    logic [2:0]  vfc;
    logic [1:0]  step, dly;
    lmva_kind_t  kind;
    int          failures, total_checks, cyc;

    lmva_core u_lmva_core (.core_clk_in(clk), .rst_n_in(rst_n), .cond_decrement_branch_exec_in(dbx), .cond_decrement_branch_disp_in(disp),
        .cond_decrement_branch_cond_true_in(cond), .cond_decrement_branch_count_in(dcnt), .body_single_word_in(sw), .body_flow_change_in(flow),
        .body_data_done_in(bdone), .fetch_req_in(freq), .data_req_in(dreq), .exc_req_in(exq), .exc_kind_in(kind),
        .exc_int_vec_in(dvec), .ack_vec_in(ack_vec), .ack_valid_in(ack_valid), .page_fault_in(pf),
        .fault_fixed_in(ffix), .vbr_wr_in(vwr), .vbr_data_in(vdata), .bus_done_in(bus_done), .low_power_halt_instr_exec_in(lps),
        .wake_event_in(wake), .loop_active_out(lact), .fetch_grant_out(fg), .data_grant_out(dg),
        .loop_count_out(lcnt), .loop_exit_out(lexit), .vbr_out(vector_table_base), .iack_out(iack), .vec_fetch_out(vf),
        .vec_addr_out(vaddr), .vec_fc_out(vfc), .exc_step_out(step), .sr_copy_out(srcp), .ctx_save_out(csave),
        .ctx_load_out(cload), .restart_out(rs), .restart_pc_out(rpc), .core_halted_out(hlt),
        .bus_shutdown_out(shut), .cur_pc_in(pc));
    lmva_mem_model u_lmva_mem_model (.clk_in(clk), .iack_in(iack), .bus_req_in(vf | csave), .dly_in(dly),
        .vec_in(dvec), .bus_done_out(bus_done), .ack_valid_out(ack_valid), .ack_vec_out(ack_vec));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            failures++;
            print_verdict();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        $display("checks=%0d failures=%0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic enter(input logic [15:0] d);
        @(negedge clk);
        {dbx, disp} = {1'b1, d};
        @(negedge clk);
        dbx = 1'b0;
    endtask
    task automatic t_vbr(input logic [31:0] d);
        @(negedge clk);
        {vwr, vdata} = {1'b1, d};
        @(negedge clk);
        vwr = 1'b0;
        vbr_exp = d;
        check(vector_table_base, d);
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_loop();
        enter(16'hfffc);
        check(lact, 1);
        check(lcnt, 16'h0002);
        check(fg, 0);
        check(dg, 1);
        bdone = 1'b1;
        @(negedge clk);
        bdone = 1'b0;
        check(lcnt, 16'h0001);
        {cond, bdone} = 2'b11;
        @(negedge clk);
        {cond, bdone} = 2'b00;
        check({lact, lexit, fg}, 3'b011);
        // Second pass runs the count down to zero
        enter(16'hfffc);
        for (int n = 2; n >= 0; n--) begin
            check(lcnt, n);
            bdone = 1'b1;
            @(negedge clk);
            bdone = 1'b0;
        end
        check({lact, lexit}, 2'b01);
    endtask
    task automatic t_noloop();
        logic [17:0] tbl[3] = '{{16'hfff8, 2'b10}, {16'hfffc, 2'b00}, {16'hfffc, 2'b11}};
        foreach (tbl[i]) begin
            {sw, flow} = tbl[i][1:0];
            enter(tbl[i][17:2]);
            check({lact, fg}, 2'b01);
        end
        {sw, flow} = 2'b10;
        dcnt = 16'h0000;
        enter(16'hfffc);
        check({lact, fg}, 2'b01);
        dcnt = 16'h0003;
    endtask
    task automatic run_exc(input lmva_kind_t k, input logic [7:0] v, input logic [1:0] d);
        logic [31:0] a[$];
        logic [2:0]  f[$];
        logic        saw_save;
        logic        saw_iack;
        {saw_save, saw_iack, dly} = {2'b00, d};
        @(negedge clk);
        {kind, dvec, exq} = {k, v, 1'b1};
        @(negedge clk);
        exq = 1'b0;
        check({srcp, step}, 3'b100);
        check(lact, 0);
        for (int n = 0; n < 60 && !cload; n++) begin
            @(posedge clk);
            if (iack) saw_iack = 1'b1;
            if (csave) saw_save = 1'b1;
            if (csave) check(step, 2'h2);
            if (vf) check(saw_save, 0);
            if (vf && bus_done) begin
                a.push_back(vaddr);
                f.push_back(vfc);
            end
        end
        check(cload, 1);
        check(saw_save, k != LMVA_KIND_RESET);
        check(saw_iack, k == LMVA_KIND_EXT);
        check(a.size(), (k == LMVA_KIND_RESET) ? 2 : 1);
        foreach (a[i]) begin
            if (k == LMVA_KIND_RESET) begin
                check(a[i], i * 4);
                check(f[i], 3'h6);
            end else begin
                check(a[i], vbr_exp + {22'h0, v, 2'b00});
                check(f[i], 3'h5);
            end
        end
        @(negedge clk);
        check(fg, 1);
    endtask
    task automatic t_fault();
        @(negedge clk);
        {pc, pf} = {32'h0000_1234, 1'b1};
        @(negedge clk);
        pf = 1'b0;
        check(dg, 0);
        repeat (2) @(negedge clk);
        ffix = 1'b1;
        @(negedge clk);
        ffix = 1'b0;
        check(rs, 1);
        check(rpc, 32'h0000_1234);
    endtask
    task automatic t_halt();
        @(negedge clk);
        lps = 1'b1;
        @(negedge clk);
        lps = 1'b0;
        repeat (3) @(negedge clk);
        check({hlt, shut, dg}, 3'b110);
        wake = 1'b1;
        @(negedge clk);
        wake = 1'b0;
        check({hlt, shut}, 2'b00);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        {rst_n, dbx, cond, bdone, exq, pf, ffix, vwr, lps, wake, flow} = '0;
        {freq, dreq, sw, disp, dvec, vdata, pc, vbr_exp, dly} = {3'b111, 16'h0, 8'h0, 96'h0, 2'h0};
        kind = LMVA_KIND_INT;
        dcnt = 16'h0003;
        {failures, total_checks, cyc} = '0;
        repeat (8) @(negedge clk);
        rst_n = 1'b1;
        check(vector_table_base, 32'h0000_0000);
        check({lact, hlt}, 2'b00);
        t_vbr(32'h0001_0000);
        t_loop();
        t_noloop();
        enter(16'hfffc);
        run_exc(LMVA_KIND_INT, 8'h08, 2'd0);
        run_exc(LMVA_KIND_EXT, 8'hff, 2'd3);
        t_vbr(32'h0000_8000);
        run_exc(LMVA_KIND_INT, 8'h00, 2'd1);
        run_exc(LMVA_KIND_RESET, 8'h00, 2'd2);
        t_fault();
        t_halt();
        print_verdict();
    end
endmodule
